// ---- design/fspp_top.sv ----
// Flash sector program/erase sequencer with read-out protection and serial tool link
`timescale 1ns/100ps
`include "fspp_cfg.svh"
module fspp_top #(
    parameter int FLASH_SIZE = 4096,
    parameter int AW         = $clog2(FLASH_SIZE)
) (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic [15:0] FETCH_ADDR,
    output logic      [7:0]  FETCH_DATA,
    input  wire logic        INCIRCUIT_SERIAL_CLOCK,
    input  wire logic        INCIRCUIT_SERIAL_DATA_I,
    output logic             INCIRCUIT_SERIAL_DATA_O,
    output logic             INCIRCUIT_SERIAL_DATA_OE_N,
    input  wire logic        VPP_PRESENT,
    input  wire logic        TOOL_ATTACHED,
    input  wire logic        BOARD_COMM_MODE_REQ,
    output logic             APP_PINS_FREE
);
    // ****************************************
    // Constants and declarations
    // ****************************************
    // Sector count
    localparam logic [1:0] NSEC = (FLASH_SIZE <= `FSPP_SEC_SIZE) ? 2'h1 :
                                  (FLASH_SIZE <= 2 * `FSPP_SEC_SIZE) ? 2'h2 : 2'h3;
    localparam logic [16:0] BASE = 17'h10000 - 17'(FLASH_SIZE);

    logic [4:0]   pin_s;
    logic         sclk_s, sdat_s, vpp_s, tool_s, comm_s;
    logic         wait_r;
    logic [31:0]  rdata_r, rd_mux;
    logic [5:0]   ctrl_r;
    logic [1:0]   guard_r;
    logic [15:0]  addr_r;
    logic [7:0]   data_r, opt_r, tx_r, fetch_r;
    logic         refused_r, sclk_d_r, link_go_r, sdo_r, oe_n_r, app_r;
    logic [5:0]   cnt_r;
    logic [3:0]   tx_cnt_r;
    logic [31:0]  sh_r, fr_r;
    fspp_pkg::fspp_state_t st_r;
    fspp_pkg::fspp_op_t    op_r, link_op, cpu_op;
    logic [15:0]  a_r;
    logic [7:0]   d_r;
    logic [1:0]   s_r;
    logic         src_link_r;
    logic [7:0]   arr_rd;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    fspp_sync #(.W(5)) u_sync (
        .clk  (CLK),
        .rstn (RSTN),
        .d    ({BOARD_COMM_MODE_REQ, TOOL_ATTACHED, VPP_PRESENT, INCIRCUIT_SERIAL_DATA_I, INCIRCUIT_SERIAL_CLOCK}),
        .q    (pin_s)
    );
    assign sclk_s = pin_s[0];
    assign sdat_s = pin_s[1];
    assign vpp_s  = pin_s[2];
    assign tool_s = pin_s[3];
    assign comm_s = pin_s[4];

    // ****************************************
    // Avalon-MM slave
    // ****************************************
    logic req, wr_acc, ctrl_wr, cpu_go, busy, prot;
    logic [7:0] wd;
    assign req     = AVS_READ | AVS_WRITE;
    assign wr_acc  = AVS_WRITE & ~wait_r & AVS_BYTEENABLE[0];
    assign wd      = AVS_WRITEDATA[7:0];
    assign ctrl_wr = wr_acc & (AVS_ADDRESS == `FSPP_OFS_CTRL);
    assign busy    = (st_r != fspp_pkg::ST_IDLE);
    assign prot    = opt_r[`FSPP_OB_PROT];

    // Waitrequest drops for exactly one cycle per request
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~(req & wait_r);
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0;
        case (AVS_ADDRESS)
            `FSPP_OFS_CTRL:  rd_mux[7:0] = {busy, 1'b0, ctrl_r};
            `FSPP_OFS_GUARD: rd_mux[1:0] = guard_r;
            `FSPP_OFS_ADDR:  rd_mux[15:0] = addr_r;
            `FSPP_OFS_DATA:  rd_mux[7:0] = data_r;
            `FSPP_OFS_OPT:   rd_mux[7:0] = opt_r;
            `FSPP_OFS_STAT:  rd_mux[4:0] = {vpp_s, prot, comm_s, refused_r, busy};
            default:         rd_mux = 32'h0;
        endcase
    end

    // Read data stands with the low waitrequest
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rdata_r <= 32'h0;
        end else if (AVS_READ & wait_r) begin
            rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ctrl_r <= `FSPP_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_r <= wd[5:0];
        end
    end

    // Address and data set by software
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            addr_r <= 16'h0000;
            data_r <= 8'h00;
        end else if (wr_acc && AVS_ADDRESS == `FSPP_OFS_ADDR) begin
            addr_r <= AVS_WRITEDATA[15:0];
        end else if (wr_acc && AVS_ADDRESS == `FSPP_OFS_DATA) begin
            data_r <= wd;
        end
    end

    // Two-key guard, consumed by any control write
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            guard_r <= 2'h0;
        end else if (ctrl_wr) begin
            guard_r <= 2'h0;
        end else if (wr_acc && AVS_ADDRESS == `FSPP_OFS_GUARD) begin
            if (wd == `FSPP_KEY1) begin
                guard_r <= 2'h1;
            end else if (wd == `FSPP_KEY2 && guard_r == 2'h1) begin
                guard_r <= 2'h2;
            end else begin
                guard_r <= 2'h0;
            end
        end
    end
    assign cpu_go = ctrl_wr & (guard_r == 2'h2) & (|wd[3:0]);

    // Lowest start bit wins
    always_comb begin
        if (wd[`FSPP_CB_PROG]) cpu_op = fspp_pkg::OP_PROG;
        else if (wd[`FSPP_CB_SECT]) cpu_op = fspp_pkg::OP_SECT;
        else if (wd[`FSPP_CB_FULL]) cpu_op = fspp_pkg::OP_FULL;
        else if (wd[`FSPP_CB_OPTW]) cpu_op = fspp_pkg::OP_OPTW;
        else cpu_op = fspp_pkg::OP_NONE;
    end

    // ****************************************
    // Serial tool link
    // ****************************************
    logic rise;
    assign rise = sclk_s & ~sclk_d_r;

    // Edge detect on the synchronised serial clock
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
        end
    end

    // Frames shift in only in comm mode
    always_ff @(posedge CLK) begin
        if (!RSTN || !comm_s) begin
            cnt_r     <= 6'h00;
            sh_r      <= 32'h0;
            fr_r      <= 32'h0;
            link_go_r <= 1'b0;
        end else begin
            link_go_r <= 1'b0;
            if (rise && tx_cnt_r == 4'h0) begin
                sh_r  <= {sh_r[30:0], sdat_s};
                cnt_r <= (cnt_r == `FSPP_FRAME_LAST) ? 6'h00 : cnt_r + 6'h01;
                if (cnt_r == `FSPP_FRAME_LAST) begin
                    fr_r      <= {sh_r[30:0], sdat_s};
                    link_go_r <= 1'b1;
                end
            end
        end
    end

    // Frame is command, address, data
    always_comb begin
        case (fr_r[31:24])
            `FSPP_CMD_PROG: link_op = fspp_pkg::OP_PROG;
            `FSPP_CMD_SECT: link_op = fspp_pkg::OP_SECT;
            `FSPP_CMD_FULL: link_op = fspp_pkg::OP_FULL;
            `FSPP_CMD_OPTW: link_op = fspp_pkg::OP_OPTW;
            `FSPP_CMD_READ: link_op = fspp_pkg::OP_READ;
            default:        link_op = fspp_pkg::OP_NONE;
        endcase
    end

    // Read reply: eight bits, one per serial clock rise
    always_ff @(posedge CLK) begin
        if (!RSTN || !comm_s) begin
            tx_r     <= 8'h00;
            tx_cnt_r <= 4'h0;
        end else if (st_r == fspp_pkg::ST_DONE && src_link_r && op_r == fspp_pkg::OP_READ) begin
            tx_r     <= prot ? 8'h00 : arr_rd;
            tx_cnt_r <= `FSPP_TX_BITS;
        end else if (rise && tx_cnt_r != 4'h0) begin
            tx_r     <= {tx_r[6:0], 1'b0};
            tx_cnt_r <= tx_cnt_r - 4'h1;
        end
    end

    // Pin drivers; enable low while driving
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sdo_r  <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            sdo_r  <= tx_r[7];
            oe_n_r <= (tx_cnt_r == 4'h0);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            app_r <= 1'b0;
        end else begin
            app_r <= ~tool_s;
        end
    end

    // ****************************************
    // Operation sequencer
    // ****************************************
    logic in_rng, prog_ok, sect_ok, full_ok, unprot, optw_ok, any_ok, exec;
    logic [1:0] a_sec;
    assign exec    = (st_r == fspp_pkg::ST_EXEC);
    assign in_rng  = ({1'b0, a_r} >= BASE);
    // Sector 0 at F000-FFFF, sector 1 below
    assign a_sec   = (fr_r[23:20] == `FSPP_SEC0_NIB) ? 2'h0 : (fr_r[23:20] == `FSPP_SEC1_NIB) ? 2'h1 : 2'h2;
    assign prog_ok = (op_r == fspp_pkg::OP_PROG) & vpp_s & ~prot & in_rng;
    assign sect_ok = (op_r == fspp_pkg::OP_SECT) & vpp_s & ~prot & (s_r < NSEC);
    assign full_ok = (op_r == fspp_pkg::OP_FULL) & vpp_s & ~prot;
    assign optw_ok = (op_r == fspp_pkg::OP_OPTW) & vpp_s & ~prot;
    assign unprot  = (op_r == fspp_pkg::OP_OPTW) & vpp_s & prot & ~d_r[`FSPP_OB_PROT];
    assign any_ok  = prog_ok | sect_ok | full_ok | optw_ok | unprot | (op_r == fspp_pkg::OP_READ);

    // Both sources reach program, erase and option write; read only from the link; link first
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            st_r       <= fspp_pkg::ST_IDLE;
            op_r       <= fspp_pkg::OP_NONE;
            a_r        <= 16'h0000;
            d_r        <= 8'h00;
            s_r        <= 2'h0;
            src_link_r <= 1'b0;
        end else begin
            case (st_r)
                fspp_pkg::ST_IDLE: begin
                    if (link_go_r) begin
                        st_r       <= fspp_pkg::ST_EXEC;
                        op_r       <= link_op;
                        a_r        <= fr_r[23:8];
                        d_r        <= fr_r[7:0];
                        s_r        <= a_sec;
                        src_link_r <= 1'b1;
                    end else if (cpu_go) begin
                        st_r       <= fspp_pkg::ST_EXEC;
                        op_r       <= cpu_op;
                        a_r        <= addr_r;
                        d_r        <= data_r;
                        s_r        <= wd[`FSPP_CB_SEC_LO+1:`FSPP_CB_SEC_LO];
                        src_link_r <= 1'b0;
                    end
                end
                fspp_pkg::ST_EXEC: st_r <= fspp_pkg::ST_DONE;
                fspp_pkg::ST_DONE: st_r <= fspp_pkg::ST_IDLE;
                default:           st_r <= fspp_pkg::ST_IDLE;
            endcase
        end
    end

    // Option byte; protection cleared together with full erase
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            opt_r <= `FSPP_OPT_RST;
        end else if (exec && (optw_ok || unprot)) begin
            opt_r <= d_r;
        end
    end

    // Refused flag: set wins over software clear
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            refused_r <= 1'b0;
        end else if ((exec && !any_ok) || (cpu_go && (busy || link_go_r))) begin
            refused_r <= 1'b1;
        end else if (wr_acc && AVS_ADDRESS == `FSPP_OFS_STAT && wd[`FSPP_SB_REFUSED]) begin
            refused_r <= 1'b0;
        end
    end

    // Fetch output holds while the port serves an operation
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            fetch_r <= 8'h00;
        end else if (st_r != fspp_pkg::ST_DONE) begin
            fetch_r <= arr_rd;
        end
    end

    // Byte write, sector or full erase
    fspp_array #(.SIZE(FLASH_SIZE), .AW(AW)) u_array (
        .clk     (CLK),
        .wr_en   (exec & prog_ok),
        .wr_idx  (a_r[AW-1:0]),
        .wr_data (d_r),
        .ers_en  (exec & (sect_ok | full_ok | unprot)),
        .ers_all (full_ok | unprot),
        .ers_sec (s_r),
        .rd_idx  (exec ? a_r[AW-1:0] : FETCH_ADDR[AW-1:0]),
        .rd_data (arr_rd)
    );

    assign AVS_READDATA               = rdata_r;
    assign AVS_WAITREQUEST            = wait_r;
    assign FETCH_DATA                 = fetch_r;
    assign INCIRCUIT_SERIAL_DATA_O    = sdo_r;
    assign INCIRCUIT_SERIAL_DATA_OE_N = oe_n_r;
    assign APP_PINS_FREE              = app_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    wait_answer_a: assert property ((req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
        else $error("request not answered in one cycle");
    prog_vpp_a: assert property ((exec && op_r == fspp_pkg::OP_PROG && !vpp_s) |=> refused_r)
        else $error("program without programming voltage not refused");
    prot_nowrite_a: assert property ((exec && op_r == fspp_pkg::OP_PROG && prot) |=> refused_r)
        else $error("protected program not refused");
    prot_read_a: assert property ((st_r == fspp_pkg::ST_DONE && src_link_r && op_r == fspp_pkg::OP_READ && prot)
        |=> (tx_r == 8'h00 && tx_cnt_r == `FSPP_TX_BITS))
        else $error("protected read leaked data");
    unprot_erase_a: assert property ((exec && op_r == fspp_pkg::OP_OPTW && prot && vpp_s && !d_r[0])
        |=> (!prot && st_r == fspp_pkg::ST_DONE))
        else $error("unprotect did not clear protection");
    guard_block_a: assert property ((ctrl_wr && guard_r != 2'h2 && !busy && !link_go_r)
        |=> st_r == fspp_pkg::ST_IDLE)
        else $error("unguarded control write started an operation");
    app_pins_a: assert property (tool_s |=> !APP_PINS_FREE)
        else $error("serial pins released while tool attached");
    sector_exist_a: assert property ((exec && op_r == fspp_pkg::OP_SECT && s_r >= NSEC) |=> refused_r)
        else $error("erase of absent sector not refused");
    done_seq_a: assert property (exec |=> st_r == fspp_pkg::ST_DONE ##1 st_r == fspp_pkg::ST_IDLE)
        else $error("sequencer did not finish in two cycles");

    prog_c: cover property (exec && prog_ok);
    sect_c: cover property (exec && sect_ok);
    unprot_c: cover property (exec && unprot);
    read_c: cover property (!INCIRCUIT_SERIAL_DATA_OE_N);
endmodule : fspp_top

// ---- design/fspp_cfg.svh ----
// Offsets, field positions, reset values and link constants of the flash sequencer
`ifndef FSPP_CFG_SVH
`define FSPP_CFG_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define FSPP_OFS_CTRL   8'h38
`define FSPP_OFS_GUARD  8'h3C
`define FSPP_OFS_ADDR   8'h40
`define FSPP_OFS_DATA   8'h44
`define FSPP_OFS_OPT    8'h48
`define FSPP_OFS_STAT   8'h4C
// ****************************************
// Fields and reset values
// ****************************************
`define FSPP_CTRL_RST   6'h00
`define FSPP_CB_PROG    0
`define FSPP_CB_SECT    1
`define FSPP_CB_FULL    2
`define FSPP_CB_OPTW    3
`define FSPP_CB_SEC_LO  4
`define FSPP_OB_PROT    0
`define FSPP_OPT_RST    8'h00
`define FSPP_SB_REFUSED 1
`define FSPP_KEY1       8'hAE
`define FSPP_KEY2       8'h56
`define FSPP_ERASED     8'hFF
`define FSPP_SEC_SIZE   4096
`define FSPP_SEC0_NIB   4'hF
`define FSPP_SEC1_NIB   4'hE
// ****************************************
// Serial link frame
// ****************************************
`define FSPP_FRAME_LAST 6'h1F
`define FSPP_TX_BITS    4'h8
`define FSPP_CMD_PROG   8'h01
`define FSPP_CMD_SECT   8'h02
`define FSPP_CMD_FULL   8'h03
`define FSPP_CMD_OPTW   8'h04
`define FSPP_CMD_READ   8'h05
`endif

// ---- design/fspp_pkg.sv ----
// Types shared by the flash sequencer modules
package fspp_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} fspp_state_t;
    typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_SECT, OP_FULL, OP_OPTW, OP_READ} fspp_op_t;
endpackage : fspp_pkg

// ---- design/fspp_sync.sv ----
// Two-stage synchroniser for pins entering the CLK domain
`timescale 1ns/100ps
module fspp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : fspp_sync

// ---- design/fspp_array.sv ----
// Flip-flop flash array with byte write, sector erase and full erase
`timescale 1ns/100ps
`include "fspp_cfg.svh"
module fspp_array #(
    parameter int SIZE = 4096,
    parameter int AW   = $clog2(SIZE)
) (
    input  wire logic          clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic [7:0]    wr_data,
    input  wire logic          ers_en,
    input  wire logic          ers_all,
    input  wire logic [1:0]    ers_sec,
    input  wire logic [AW-1:0] rd_idx,
    output logic      [7:0]    rd_data
);
    logic [7:0] mem [SIZE];

    // Sector of an index; the array sits at the top of the address space
    function automatic logic [1:0] sec_of(input int i);
        int d;
        d = (SIZE - 1 - i) / `FSPP_SEC_SIZE;
        return (d > 1) ? 2'h2 : d[1:0];
    endfunction : sec_of

    always_ff @(posedge clk) begin
        if (ers_en) begin
            for (int i = 0; i < SIZE; i++) begin
                if (ers_all || sec_of(i) == ers_sec) begin
                    mem[i] <= `FSPP_ERASED;
                end
            end
        end else if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_idx];
    end
endmodule : fspp_array

// ---- tb/fspp_tool_model.sv ----
// Programming tool model: drives the serial link clock, data and comm request
`timescale 1ns/100ps
module fspp_tool_model (
    output logic      sclk,
    output logic      sdat,
    output logic      comm,
    input  wire logic data_line
);
    logic drv    = 1'b0;
    logic bit_v  = 1'b0;
    logic idle_t = 1'b0;
    initial sclk = 1'b0;
    initial comm = 1'b0;
    // Released data line shows a changing pattern, never the last bit
    always #40 idle_t = ~idle_t;
    assign sdat = drv ? bit_v : idle_t;
    // the bench clock stands in for the main clock input
    // comm mode raised before any frame
    // clock and data lines driven, clock still between frames
    task automatic frame(input logic [7:0] cmd, input logic [15:0] adr, input logic [7:0] dat);
        logic [31:0] w;
        w = {cmd, adr, dat};
        #4; // Move off the CLK sampling edge
        comm = 1'b1;
        drv = 1'b1;
        for (int i = 31; i >= 0; i--) begin
            bit_v = w[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        drv = 1'b0;
        #400;
    endtask : frame
    // Reply bits taken just before each rise, MSB first
    task automatic reply(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #80 b[i] = data_line;
            sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #400;
    endtask : reply
endmodule : fspp_tool_model

// ---- tb/flash_sector_program_protect_test.sv ----
// Self-checking bench of the flash sector sequencer
`timescale 1ns/100ps
`include "fspp_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module flash_sector_program_protect_test;
    logic        clk      = 1'b0;
    logic        rstn     = 1'b0;
    logic [7:0]  adr      = 8'h00;
    logic        rd_s     = 1'b0;
    logic        wr_s     = 1'b0;
    logic [31:0] wdat     = 32'h0;
    logic [15:0] faddr    = 16'h0;
    logic        vpp      = 1'b1;
    logic        attached = 1'b0;
    logic [31:0] rdat;
    logic        wreq, sclk, sdat_t, comm, d_o, oe_n, pins_free;
    logic [7:0]  fdata, d0, d1, r;
    logic [15:0] a0, a1;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    integer      seed       = 32'hF28D02EE;
    wire         data_line  = (oe_n === 1'b0) ? d_o : sdat_t;
    fspp_top #(.FLASH_SIZE(8192)) u_dut (
        .CLK(clk), .RSTN(rstn), .AVS_ADDRESS(adr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .FETCH_ADDR(faddr), .FETCH_DATA(fdata), .INCIRCUIT_SERIAL_CLOCK(sclk),
        .INCIRCUIT_SERIAL_DATA_I(data_line), .INCIRCUIT_SERIAL_DATA_O(d_o),
        .INCIRCUIT_SERIAL_DATA_OE_N(oe_n), .VPP_PRESENT(vpp), .TOOL_ATTACHED(attached),
        .BOARD_COMM_MODE_REQ(comm), .APP_PINS_FREE(pins_free));
    fspp_tool_model u_tool (.sclk(sclk), .sdat(sdat_t), .comm(comm), .data_line(data_line));
    // Clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        adr  <= a;
        wr_s <= w;
        rd_s <= !w;
        wdat <= {16'h0, d};
        do @(posedge clk); while (wreq !== 1'b0);
        r = rdat[7:0];
        wr_s <= 1'b0;
        rd_s <= 1'b0;
    endtask : bus
    // Armed start of an operation, then wait for busy to clear
    task automatic op(input logic [7:0] c);
        bus(1'b1, `FSPP_OFS_GUARD, {8'h00, `FSPP_KEY1});
        bus(1'b1, `FSPP_OFS_GUARD, {8'h00, `FSPP_KEY2});
        bus(1'b1, `FSPP_OFS_CTRL, {8'h00, c});
        repeat (20) begin
            bus(1'b0, `FSPP_OFS_CTRL, 16'h0000);
            if (r[7] === 1'b0) break;
        end
        `CHK(r[7], 1'b0)
    endtask : op
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, `FSPP_OFS_ADDR, a);
        bus(1'b1, `FSPP_OFS_DATA, {8'h00, d});
        op(8'h01);
    endtask : prog
    task automatic fetch(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        faddr <= a;
        repeat (3) @(posedge clk);
        `CHK(fdata, e)
    endtask : fetch
    function automatic logic [7:0] ctl(int b, logic [1:0] s);
        return (8'h01 << b) | {2'h0, s, 4'h0};
    endfunction : ctl
    // Sector s sits 4 Kbytes below sector s-1, sector 0 at the top
    function automatic logic [15:0] sec_adr(logic [1:0] s, logic [11:0] off);
        return {4'hF - {2'h0, s}, off};
    endfunction : sec_adr
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        a0 = sec_adr(2'h0, 12'($random(seed)));
        a1 = sec_adr(2'h1, 12'($random(seed)));
        d0 = {1'b0, 7'($random(seed))} | 8'h01;
        d1 = {1'b0, 7'($random(seed))} | 8'h01;
        bus(1'b0, `FSPP_OFS_CTRL, 16'h0000);
        `CHK(r, 8'h00)
        bus(1'b0, `FSPP_OFS_OPT, 16'h0000);
        `CHK(r, `FSPP_OPT_RST)
        bus(1'b1, 8'h10, 16'h00FF);
        bus(1'b0, 8'h10, 16'h0000);
        `CHK(r, 8'h00)
        bus(1'b1, `FSPP_OFS_CTRL, 16'h0020);
        bus(1'b0, `FSPP_OFS_CTRL, 16'h0000);
        `CHK(r, 8'h20)
        `CHK(pins_free, 1'b1)
        op(ctl(`FSPP_CB_FULL, 2'h0));
        fetch(a0, `FSPP_ERASED);
        prog(a0, d0);
        prog(a1, d1);
        fetch(a0, d0);
        fetch(a1, d1);
        op(ctl(`FSPP_CB_SECT, 2'h1));
        fetch(a1, `FSPP_ERASED);
        fetch(a0, d0);
        op(ctl(`FSPP_CB_SECT, 2'h2));
        bus(1'b0, `FSPP_OFS_STAT, 16'h0000);
        `CHK(r[`FSPP_SB_REFUSED], 1'b1)
        bus(1'b1, `FSPP_OFS_STAT, 16'h0002);
        bus(1'b1, `FSPP_OFS_ADDR, a1);
        bus(1'b1, `FSPP_OFS_DATA, {8'h00, d1});
        bus(1'b1, `FSPP_OFS_CTRL, 16'h0001);
        repeat (8) @(posedge clk);
        fetch(a1, `FSPP_ERASED);
        vpp <= 1'b0;
        prog(a1, d1);
        fetch(a1, `FSPP_ERASED);
        vpp <= 1'b1;
        attached <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK(pins_free, 1'b0)
        u_tool.frame(`FSPP_CMD_PROG, a1, d1);
        fetch(a1, d1);
        u_tool.frame(`FSPP_CMD_READ, a0, 8'h00);
        `CHK(oe_n, 1'b0)
        u_tool.reply(d1);
        `CHK(d1, d0)
        `CHK(oe_n, 1'b1)
        bus(1'b1, `FSPP_OFS_DATA, 16'h0001);
        op(ctl(`FSPP_CB_OPTW, 2'h0));
        bus(1'b0, `FSPP_OFS_OPT, 16'h0000);
        `CHK(r[`FSPP_OB_PROT], 1'b1)
        u_tool.frame(`FSPP_CMD_READ, a0, 8'h00);
        u_tool.reply(d1);
        `CHK(d1, 8'h00)
        prog(a0, 8'h00);
        op(ctl(`FSPP_CB_SECT, 2'h0));
        fetch(a0, d0);
        bus(1'b1, `FSPP_OFS_DATA, 16'h0000);
        op(ctl(`FSPP_CB_OPTW, 2'h0));
        bus(1'b0, `FSPP_OFS_OPT, 16'h0000);
        `CHK(r, 8'h00)
        fetch(a0, `FSPP_ERASED);
        fetch(a1, `FSPP_ERASED);
        attached <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK(pins_free, 1'b1)
        // Random bytes into erased places of sector 0 or 1, the sector picked at random each time
        for (int i = 0; i < 4; i++) begin
            a0 = sec_adr(2'($random(seed)) & 2'h1, 12'($random(seed)));
            d0 = 8'($random(seed));
            prog(a0, d0);
            fetch(a0, d0);
        end
        give_verdict();
    end
endmodule : flash_sector_program_protect_test
